/* hdl/prs_consts.svh */
// Constants for the power resource sequencer: resource indices, widths, reset values and timing.
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
`define PRS_NUM_RES 8
`define PRS_NUM_CLKREQ 4
`define PRS_NUM_TIMERS 2
`define PRS_DELAY_W 8
`define PRS_RTMR_W 16
`define PRS_RES_CORE_BUCK_REGULATOR 0
`define PRS_RES_CORE_LINEAR_REGULATOR 1
`define PRS_RES_LOW_NOISE_LINEAR_REGULATOR 2
`define PRS_RES_XTAL 3
`define PRS_RES_PLL 4
`define PRS_RES_RADIO 5
`define PRS_RES_CORE 6
`define PRS_RES_SBLDO 7
`define PRS_PWR_ON_MASK 8'h07
`define PRS_MIN_MASK_RST 8'h00
`define PRS_PULLDOWN_RST 1'b1
`define PRS_LPO_HZ 32768
`define PRS_CORE_HZ 100000000
`define PRS_TICK_DIV (`PRS_CORE_HZ / `PRS_LPO_HZ)
`endif

/* hdl/prs_pkg.sv */
// Types shared by the power resource sequencer.
package prs_pkg;
    typedef enum logic [1:0] {
        PRS_DISABLED,
        PRS_TURN_ON,
        PRS_ENABLED,
        PRS_TURN_OFF
    } prs_res_state_t;
    typedef enum logic [1:0] {
        PRS_PM_ACTIVE,
        PRS_PM_DOZE,
        PRS_PM_DEEP_SLEEP,
        PRS_PM_POWER_DOWN
    } prs_pm_mode_t;
endpackage : prs_pkg

/* hdl/prs_resource.sv */
// One power resource: four-state enable/disable machine with its transition countdown.
`timescale 1ns/1ps
`include "prs_consts.svh"
module prs_resource
    import prs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic tick_in,
    // Decisions and delays.
    input wire logic start_on_in,
    input wire logic start_off_in,
    input wire logic [`PRS_DELAY_W-1:0] delay_on_in,
    input wire logic [`PRS_DELAY_W-1:0] delay_off_in,
    // State.
    output prs_res_state_t state_out,
    output logic [`PRS_DELAY_W-1:0] timer_out,
    output logic on_flag_out,
    output logic pending_out
);
    prs_res_state_t state_reg, state_next;
    logic [`PRS_DELAY_W-1:0] timer_reg, timer_next;
    logic on_reg, on_next;
    wire logic timer_last = tick_in && (timer_reg == `PRS_DELAY_W'(1));

    // Load on a decision, count down on each tick, flip the on flag when the count ends.
    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        on_next = on_reg;
        unique case (state_reg)
            PRS_DISABLED:
            begin
                if (start_on_in && tick_in)
                begin
                    if (delay_on_in == '0)
                    begin
                        state_next = PRS_ENABLED;
                        on_next = 1'b1;
                    end
                    else
                    begin
                        state_next = PRS_TURN_ON;
                        timer_next = delay_on_in;
                    end
                end
            end
            PRS_ENABLED:
            begin
                if (start_off_in && tick_in)
                begin
                    if (delay_off_in == '0)
                    begin
                        state_next = PRS_DISABLED;
                        on_next = 1'b0;
                    end
                    else
                    begin
                        state_next = PRS_TURN_OFF;
                        timer_next = delay_off_in;
                    end
                end
            end
            PRS_TURN_ON, PRS_TURN_OFF:
            begin
                if (tick_in)
                    timer_next = timer_reg - `PRS_DELAY_W'(1);
                if (timer_last)
                begin
                    state_next = (state_reg == PRS_TURN_ON) ? PRS_ENABLED : PRS_DISABLED;
                    on_next = ~on_reg;
                end
            end
        endcase
    end

    // Reset leaves every resource off with a clear timer.
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            state_reg <= PRS_DISABLED;
            timer_reg <= '0;
            on_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            on_reg <= on_next;
        end
    end

    assign state_out = state_reg;
    assign timer_out = timer_reg;
    assign on_flag_out = on_reg;
    assign pending_out = (state_reg == PRS_TURN_ON) || (state_reg == PRS_TURN_OFF);

    // The timer is zero exactly in the settled states.
    AST_TIMER_ZERO: assert property (@(posedge core_clk_in) disable iff (srst_in)
        ((state_reg == PRS_ENABLED) || (state_reg == PRS_DISABLED)) == (timer_reg == '0))
        else $error("Timer value disagrees with resource state.");
endmodule : prs_resource

/* hdl/prs_sequencer.sv */
// Power resource sequencer: request gathering, dependency resolution and power mode control.
`timescale 1ns/1ps
`include "prs_consts.svh"
// Contract
// - Two host power-on inputs, one per radio section, enable regulators and release resets.
// - Core buck, core linear and low-noise regulators start when either input goes active.
// - All regulators power down only when both power-on inputs are inactive.
// - Core linear and low-noise regulators may switch at run time by baseband demand; here both stay requested while either power-on input is high.
// - Requested set is union of clock requests, minimum mask and active request timers.
// - Each clock request maps to its needed resources before combining.
// - Each resource is enabled, disabled, turning on or turning off.
// - Transition timer is zero when settled and non-zero while transitioning.
// - A start decision loads the enable or disable delay into the timer.
// - Non-zero timers decrement once per low-power clock tick.
// - At timer zero the transition completes, pending clears, on flag inverts.
// - A zero delay makes the transition immediate.
// - Each tick recompute required set from requests and dependencies, compare with status.
// - Disable an enabled, unrequested resource with no powered dependents.
// - Enable a disabled, requested resource whose dependencies are all enabled.
// - In doze main clocks stop; only the low-power clock runs the sequencer; here the sequencer still runs on core_clk_in and steps resources on each tick.
// - Save core state to retention before deep sleep, restore it on wake.
// - Leave deep sleep on timer expiry, external interrupt or host resume.
// - Free-running counters at the low-power rate switch regulators and switches; here request timers are one-shot countdowns started by timer_start_in.
// - Wireless LAN section is out of reset while its power-on input is high.
// - Power-on input pull-downs are on after reset and software can disable them.
module prs_sequencer
    import prs_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Host power-on pins.
    input wire logic wireless_lan_power_on_in,
    input wire logic short_range_radio_power_on_in,
    // Configuration.
    input wire logic [`PRS_NUM_RES-1:0] minimum_resource_mask_in,
    input wire logic [`PRS_NUM_RES*`PRS_NUM_RES-1:0] dependency_table_in,
    input wire logic [`PRS_NUM_RES*`PRS_DELAY_W-1:0] delay_on_in,
    input wire logic [`PRS_NUM_RES*`PRS_DELAY_W-1:0] delay_off_in,
    input wire logic [`PRS_NUM_CLKREQ*`PRS_NUM_RES-1:0] clock_map_in,
    input wire logic [`PRS_NUM_TIMERS*`PRS_NUM_RES-1:0] timer_res_mask_in,
    input wire logic [`PRS_NUM_TIMERS*`PRS_RTMR_W-1:0] timer_period_in,
    input wire logic [`PRS_NUM_TIMERS-1:0] timer_start_in,
    input wire logic pulldown_disable_in,
    // Requests and wake events.
    input wire logic [`PRS_NUM_CLKREQ-1:0] clock_request_in,
    input wire logic doze_request_in,
    input wire logic deep_sleep_request_in,
    input wire logic ext_wake_in,
    input wire logic host_resume_in,
    input wire logic core_state_in,
    // Outputs.
    output logic [`PRS_NUM_RES-1:0] resource_on_flag_out,
    output logic [`PRS_NUM_RES-1:0] resource_transition_flag_out,
    output logic wireless_lan_reset_out,
    output logic short_range_radio_reset_out,
    output logic pulldown_enable_out,
    output logic main_clock_enable_out,
    output logic core_power_enable_out,
    output logic retention_save_out,
    output logic retention_restore_out,
    output logic retained_state_out,
    output prs_pm_mode_t pm_mode_out
);
    localparam int NR = `PRS_NUM_RES;
    localparam int DW = `PRS_DELAY_W;
    localparam int TDIV = `PRS_TICK_DIV;

    // Pins from the host pass two flip-flops; asynchronous inputs likewise.
    logic [3:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= {host_resume_in, ext_wake_in, short_range_radio_power_on_in, wireless_lan_power_on_in};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    wire logic wl_on = pin_s2_reg[0];
    wire logic sr_on = pin_s2_reg[1];
    wire logic ext_wake = pin_s2_reg[2];
    wire logic host_resume = pin_s2_reg[3];
    wire logic any_power_on = wl_on | sr_on;

    // Divider producing the low-power sequencer tick from the core clock.
    logic [15:0] div_reg;
    wire logic tick = (div_reg == 16'(TDIV - 1));
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            div_reg <= '0;
        else
            div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
    end

    // Request timers: one-shot countdowns that hold their resources while active.
    logic [`PRS_NUM_TIMERS-1:0] tmr_active_reg;
    logic [`PRS_NUM_TIMERS-1:0] tmr_expire_reg;
    logic [`PRS_RTMR_W-1:0] tmr_cnt_reg [`PRS_NUM_TIMERS];
    logic [NR-1:0] timer_req;
    always_comb
    begin
        timer_req = '0;
        for (int t = 0; t < `PRS_NUM_TIMERS; t++)
            if (tmr_active_reg[t])
                timer_req = timer_req | timer_res_mask_in[t*NR +: NR];
    end
    always_ff @(posedge core_clk_in)
    begin
        for (int t = 0; t < `PRS_NUM_TIMERS; t++)
        begin
            if (srst_in)
            begin
                tmr_active_reg[t] <= 1'b0;
                tmr_expire_reg[t] <= 1'b0;
                tmr_cnt_reg[t] <= '0;
            end
            else
            begin
                tmr_expire_reg[t] <= 1'b0;
                if (timer_start_in[t])
                begin
                    tmr_active_reg[t] <= 1'b1;
                    tmr_cnt_reg[t] <= timer_period_in[t*`PRS_RTMR_W +: `PRS_RTMR_W];
                end
                else if (tick && tmr_active_reg[t])
                begin
                    if (tmr_cnt_reg[t] <= 16'h0001)
                    begin
                        tmr_active_reg[t] <= 1'b0;
                        tmr_expire_reg[t] <= 1'b1;
                        tmr_cnt_reg[t] <= '0;
                    end
                    else
                        tmr_cnt_reg[t] <= tmr_cnt_reg[t] - 16'h0001;
                end
            end
        end
    end
    wire logic timer_wake = |tmr_expire_reg;

    // Clock requests mapped to resources, then the union of all sources.
    logic [NR-1:0] clk_req_res;
    always_comb
    begin
        clk_req_res = '0;
        for (int c = 0; c < `PRS_NUM_CLKREQ; c++)
            if (clock_request_in[c])
                clk_req_res = clk_req_res | clock_map_in[c*NR +: NR];
    end
    wire logic [NR-1:0] pin_req = any_power_on ? NR'(`PRS_PWR_ON_MASK) : '0;
    wire logic [NR-1:0] direct_req = any_power_on ?
        (clk_req_res | minimum_resource_mask_in | timer_req | pin_req) : '0;

    // Dependency closure: a requested resource requests what it depends on.
    logic [NR-1:0] required;
    always_comb
    begin
        required = direct_req;
        for (int pass = 0; pass < NR; pass++)
            for (int r = 0; r < NR; r++)
                if (required[r])
                    required = required | dependency_table_in[r*NR +: NR];
    end

    // Per-resource decisions from request, dependencies and dependents.
    prs_res_state_t res_state [NR];
    logic [NR-1:0] on_flag, pend_flag, start_on, start_off;
    logic [DW-1:0] res_timer [NR];
    logic [NR-1:0] is_enabled, is_powered;
    always_comb
    begin
        for (int r = 0; r < NR; r++)
        begin
            is_enabled[r] = (res_state[r] == PRS_ENABLED);
            is_powered[r] = (res_state[r] != PRS_DISABLED);
        end
        for (int r = 0; r < NR; r++)
        begin
            start_on[r] = required[r] &&
                ((dependency_table_in[r*NR +: NR] & ~is_enabled) == '0);
            start_off[r] = !required[r];
            for (int d = 0; d < NR; d++)
                if (dependency_table_in[d*NR + r] && is_powered[d])
                    start_off[r] = 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NR; g++)
        begin : gen_res
            prs_resource prs_resource_inst (
                .core_clk_in(core_clk_in),
                .srst_in(srst_in),
                .tick_in(tick),
                .start_on_in(start_on[g]),
                .start_off_in(start_off[g]),
                .delay_on_in(delay_on_in[g*DW +: DW]),
                .delay_off_in(delay_off_in[g*DW +: DW]),
                .state_out(res_state[g]),
                .timer_out(res_timer[g]),
                .on_flag_out(on_flag[g]),
                .pending_out(pend_flag[g])
            );
        end
    endgenerate

    // Power mode machine covering doze, deep sleep with retention, and power-down.
    prs_pm_mode_t mode_reg, mode_next;
    wire logic wake = timer_wake | ext_wake | host_resume;
    always_comb
    begin
        mode_next = mode_reg;
        unique case (mode_reg)
            PRS_PM_ACTIVE:
                if (!any_power_on)
                    mode_next = PRS_PM_POWER_DOWN;
                else if (deep_sleep_request_in)
                    mode_next = PRS_PM_DEEP_SLEEP;
                else if (doze_request_in)
                    mode_next = PRS_PM_DOZE;
            PRS_PM_DOZE, PRS_PM_DEEP_SLEEP:
                if (!any_power_on)
                    mode_next = PRS_PM_POWER_DOWN;
                else if (wake)
                    mode_next = PRS_PM_ACTIVE;
            PRS_PM_POWER_DOWN:
                if (any_power_on)
                    mode_next = PRS_PM_ACTIVE;
        endcase
    end

    // Registered outputs; the retention word lives in the always-on domain.
    logic retained_reg;
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            mode_reg <= PRS_PM_POWER_DOWN;
            retained_reg <= 1'b0;
            retention_save_out <= 1'b0;
            retention_restore_out <= 1'b0;
            main_clock_enable_out <= 1'b0;
            core_power_enable_out <= 1'b0;
            wireless_lan_reset_out <= 1'b1;
            short_range_radio_reset_out <= 1'b1;
            pulldown_enable_out <= `PRS_PULLDOWN_RST;
            resource_on_flag_out <= '0;
            resource_transition_flag_out <= '0;
        end
        else
        begin
            mode_reg <= mode_next;
            retention_save_out <= (mode_reg == PRS_PM_ACTIVE) && (mode_next == PRS_PM_DEEP_SLEEP);
            retention_restore_out <= (mode_reg == PRS_PM_DEEP_SLEEP) && (mode_next == PRS_PM_ACTIVE);
            if ((mode_reg == PRS_PM_ACTIVE) && (mode_next == PRS_PM_DEEP_SLEEP))
                retained_reg <= core_state_in;
            main_clock_enable_out <= (mode_next == PRS_PM_ACTIVE);
            core_power_enable_out <= (mode_next == PRS_PM_ACTIVE) || (mode_next == PRS_PM_DOZE);
            wireless_lan_reset_out <= !wl_on;
            short_range_radio_reset_out <= !sr_on;
            pulldown_enable_out <= !pulldown_disable_in;
            resource_on_flag_out <= on_flag;
            resource_transition_flag_out <= pend_flag;
        end
    end
    assign retained_state_out = retained_reg;
    assign pm_mode_out = mode_reg;

    // No resource is requested while both power-on pins are low.
    AST_NO_REQ_WHEN_OFF: assert property (@(posedge core_clk_in) disable iff (srst_in)
        !any_power_on |-> (direct_req == '0))
        else $error("Resources requested with both power-on inputs low.");
    AST_PWRON_REQ: assert property (@(posedge core_clk_in) disable iff (srst_in)
        any_power_on |-> required[`PRS_RES_CORE_BUCK_REGULATOR] && required[`PRS_RES_CORE_LINEAR_REGULATOR] && required[`PRS_RES_LOW_NOISE_LINEAR_REGULATOR])
        else $error("Core regulators not requested while powered on.");
    AST_WL_RESET: assert property (@(posedge core_clk_in) disable iff (srst_in)
        $rose(wl_on) |=> !wireless_lan_reset_out)
        else $error("Wireless LAN section not released from reset.");
    AST_DOZE_CLK: assert property (@(posedge core_clk_in) disable iff (srst_in)
        (mode_reg == PRS_PM_DOZE) |-> !main_clock_enable_out)
        else $error("Main clocks running in doze.");
    AST_SAVE: assert property (@(posedge core_clk_in) disable iff (srst_in)
        (mode_reg == PRS_PM_ACTIVE) ##1 (mode_reg == PRS_PM_DEEP_SLEEP) |-> retention_save_out)
        else $error("Core state not saved on deep sleep entry.");
    AST_WAKE: assert property (@(posedge core_clk_in) disable iff (srst_in)
        (mode_reg == PRS_PM_DEEP_SLEEP) && any_power_on && wake |=> (mode_reg == PRS_PM_ACTIVE))
        else $error("Deep sleep not left on a wake event.");
    // The PLL may only leave the disabled state once all it depends on is enabled.
    wire logic pll_deps_ok = ((dependency_table_in[`PRS_RES_PLL*NR +: NR] & ~is_enabled) == '0);
    AST_ON_NEEDS_DEPS: assert property (@(posedge core_clk_in) disable iff (srst_in)
        (res_state[`PRS_RES_PLL] == PRS_DISABLED) ##1 (res_state[`PRS_RES_PLL] != PRS_DISABLED) |-> $past(pll_deps_ok))
        else $error("Resource started before its dependencies were enabled.");
    AST_PULLDOWN: assert property (@(posedge core_clk_in) disable iff (srst_in)
        pulldown_disable_in |=> !pulldown_enable_out)
        else $error("Pull-down not disabled on request.");
    AST_OFF_DEPENDENT: assert property (@(posedge core_clk_in) disable iff (srst_in)
        start_off[`PRS_RES_CORE_BUCK_REGULATOR] |-> !(dependency_table_in[`PRS_RES_CORE_LINEAR_REGULATOR*NR + `PRS_RES_CORE_BUCK_REGULATOR] && is_powered[`PRS_RES_CORE_LINEAR_REGULATOR]))
        else $error("Resource switched off under a powered dependent.");
    COV_DEEP: cover property (@(posedge core_clk_in) mode_reg == PRS_PM_DEEP_SLEEP ##1 mode_reg == PRS_PM_ACTIVE);
    COV_DOZE: cover property (@(posedge core_clk_in) mode_reg == PRS_PM_DOZE);
    COV_CORE_ON: cover property (@(posedge core_clk_in) resource_on_flag_out[`PRS_RES_CORE_BUCK_REGULATOR]);
endmodule : prs_sequencer

/* bench/prs_host_model.sv */
// Host-side model that drives the two section power-on pins.
`timescale 1ns/1ps
module prs_host_model
(
    // Clock.
    input wire logic core_clk_in,
    // Commands from the bench.
    input wire logic wlan_cmd_in,
    input wire logic srr_cmd_in,
    // Power-on pins.
    output logic wireless_lan_power_on_out,
    output logic short_range_radio_power_on_out
);
    // Pins start low, as the pull-down holds them before the host acts.
    initial
    begin
        wireless_lan_power_on_out = 1'b0;
        short_range_radio_power_on_out = 1'b0;
    end
    // Pins move just after the falling edge; an unknown command reads as released, so the pull-down wins.
    always @(negedge core_clk_in)
    begin
        wireless_lan_power_on_out <= (wlan_cmd_in === 1'b1);
        short_range_radio_power_on_out <= (srr_cmd_in === 1'b1);
    end
endmodule : prs_host_model

/* bench/prs_sequencer_tb.sv */
// Self-checking bench for the power resource sequencer against a behavioural resource model.
`timescale 1ns/1ps
`include "prs_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module prs_sequencer_tb import prs_pkg::*;;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic wl_cmd = 1'b0;
    logic srr_cmd = 1'b0;
    logic wl_pin;
    logic srr_pin;
    logic [7:0] min_mask = 8'h00;
    logic [63:0] dep_tbl = 64'h0;
    logic [63:0] don = 64'h0;
    logic [63:0] doff = 64'h0;
    logic [31:0] cmap = 32'h0;
    logic [3:0] creq = 4'h0;
    logic pd_dis = 1'b0;
    logic deep_req = 1'b0;
    logic host_res = 1'b0;
    logic core_st = 1'b0;
    logic doze_req = 1'b0;
    logic ext_wk = 1'b0;
    logic [1:0] tstart = 2'h0;
    logic [15:0] tmask = 16'h0020;
    logic [31:0] tper = 32'h00000003;
    logic rsave, rrest;
    int save_seen = 0;
    int rest_seen = 0;
    logic [7:0] on_flags;
    logic [7:0] tr_flags;
    logic wl_rst, srr_rst, pd_en, mclk_en, cpwr_en, rstate;
    prs_pm_mode_t pm_mode;
    logic [7:0] b;
    logic [31:0] lfsr_reg = 32'h0001132D;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;

    prs_host_model prs_host_model_inst (.core_clk_in(core_clk_in), .wlan_cmd_in(wl_cmd), .srr_cmd_in(srr_cmd),
        .wireless_lan_power_on_out(wl_pin), .short_range_radio_power_on_out(srr_pin));

    // Request timer 0 holds resource 5 for a few ticks; timer 1 stays idle.
    prs_sequencer prs_sequencer_inst (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .wireless_lan_power_on_in(wl_pin), .short_range_radio_power_on_in(srr_pin),
        .minimum_resource_mask_in(min_mask), .dependency_table_in(dep_tbl), .delay_on_in(don),
        .delay_off_in(doff), .clock_map_in(cmap), .timer_res_mask_in(tmask), .timer_period_in(tper),
        .timer_start_in(tstart), .pulldown_disable_in(pd_dis), .clock_request_in(creq), .doze_request_in(doze_req),
        .deep_sleep_request_in(deep_req), .ext_wake_in(ext_wk), .host_resume_in(host_res), .core_state_in(core_st),
        .resource_on_flag_out(on_flags), .resource_transition_flag_out(tr_flags), .wireless_lan_reset_out(wl_rst),
        .short_range_radio_reset_out(srr_rst), .pulldown_enable_out(pd_en), .main_clock_enable_out(mclk_en),
        .core_power_enable_out(cpwr_en), .retention_save_out(rsave), .retention_restore_out(rrest),
        .retained_state_out(rstate), .pm_mode_out(pm_mode));

    // Count the one-cycle retention pulses so that none is missed between checks.
    always @(posedge core_clk_in)
    begin
        if (rsave === 1'b1) save_seen++;
        if (rrest === 1'b1) rest_seen++;
    end

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Random bytes from a fixed-seed shift register.
    function automatic logic [7:0] lfsr_byte();
        lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        return lfsr_reg[7:0];
    endfunction : lfsr_byte

    // Settled resource set: clock requests, minimum mask and power-on set, closed over dependencies; nothing while both pins are low.
    function automatic logic [7:0] model_on();
        logic [7:0] req;
        req = min_mask | 8'h07;
        for (int c = 0; c < 4; c++)
            if (creq[c]) req |= cmap[c*8 +: 8];
        for (int k = 0; k < 8; k++)
            for (int r = 0; r < 8; r++)
                if (req[r]) req |= dep_tbl[r*8 +: 8];
        return (wl_pin | srr_pin) ? req : 8'h00;
    endfunction : model_on

    task automatic cyc_wait(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc_wait

    task automatic ticks(input int n);
        cyc_wait(n * `PRS_TICK_DIV);
    endtask : ticks

    // Bounded wait for a power mode, up to three tick periods; the mode can move on any core clock cycle.
    task automatic wait_mode(input prs_pm_mode_t m);
        int n;
        n = 0;
        while (pm_mode !== m && n < 3 * `PRS_TICK_DIV)
        begin
            cyc_wait(1);
            n++;
        end
        `CHK(pm_mode, m)
    endtask : wait_mode

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard, sized some 15k cycles above the roughly 95k cycles the sequence needs.
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 110000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    // Main sequence; all inputs change at the falling edge.
    initial
    begin
        cyc_wait(6);
        srst_in = 1'b0;
        cyc_wait(1);
        `CHK({on_flags, tr_flags}, 16'h0000)
        `CHK({wl_rst, srr_rst, pd_en}, 3'h7)
        `CHK({mclk_en, cpwr_en, pm_mode}, {2'h0, PRS_PM_POWER_DOWN})
        pd_dis = 1'b1;
        cyc_wait(4);
        `CHK(pd_en, 1'b0)
        pd_dis = 1'b0;
        $display("test reset done");
        wl_cmd = 1'b1;
        cyc_wait(6);
        `CHK({wl_rst, srr_rst}, 2'h1)
        ticks(2);
        `CHK(on_flags, model_on())
        wait_mode(PRS_PM_ACTIVE);
        `CHK(mclk_en, 1'b1)
        wl_cmd = 1'b0;
        srr_cmd = 1'b1;
        cyc_wait(6);
        `CHK({wl_rst, srr_rst}, 2'h2)
        ticks(2);
        `CHK(on_flags, model_on())
        wl_cmd = 1'b1;
        $display("test pins done");
        for (int i = 0; i < 2; i++)
        begin
            min_mask = lfsr_byte();
            cmap = {lfsr_byte(), lfsr_byte(), lfsr_byte(), lfsr_byte()};
            b = lfsr_byte();
            creq = b[3:0];
            core_st = b[4];
            for (int r = 0; r < 8; r++)
                dep_tbl[r*8 +: 8] = lfsr_byte() & ((8'h01 << r) - 8'h01) & 8'h0F;
            ticks(6);
            `CHK(on_flags, model_on())
            `CHK(tr_flags, 8'h00)
        end
        $display("test random requests done");
        dep_tbl = 64'h0;
        creq = 4'h0;
        min_mask = 8'h00;
        ticks(2);
        `CHK(on_flags, model_on())
        don[24 +: 8] = 8'h03;
        min_mask = 8'h08;
        b = 8'h00;
        while (tr_flags[3] !== 1'b1 && b < 8'hFF)
        begin
            cyc_wait(24);
            b++;
        end
        `CHK({tr_flags[3], on_flags[3]}, 2'h2)
        ticks(2);
        `CHK(tr_flags[3], 1'b1)
        ticks(2);
        `CHK({tr_flags[3], on_flags[3]}, 2'h1)
        $display("test timed enable done");
        tstart = 2'h1;
        cyc_wait(1);
        tstart = 2'h0;
        ticks(2);
        `CHK(on_flags[5], 1'b1)
        ticks(3);
        `CHK(on_flags, model_on())
        $display("test request timer done");
        deep_req = 1'b1;
        wait_mode(PRS_PM_DEEP_SLEEP);
        `CHK({rstate, mclk_en, cpwr_en}, {core_st, 2'h0})
        deep_req = 1'b0;
        host_res = 1'b1;
        wait_mode(PRS_PM_ACTIVE);
        `CHK({rstate, cpwr_en}, {core_st, 1'b1})
        host_res = 1'b0;
        cyc_wait(1);
        `CHK(save_seen, 1)
        `CHK(rest_seen, 1)
        $display("test deep sleep done");
        doze_req = 1'b1;
        wait_mode(PRS_PM_DOZE);
        `CHK({mclk_en, cpwr_en}, 2'h1)
        doze_req = 1'b0;
        ext_wk = 1'b1;
        wait_mode(PRS_PM_ACTIVE);
        `CHK({mclk_en, cpwr_en}, 2'h3)
        ext_wk = 1'b0;
        $display("test doze done");
        wl_cmd = 1'b0;
        srr_cmd = 1'b0;
        ticks(3);
        `CHK(on_flags, model_on())
        `CHK(pm_mode, PRS_PM_POWER_DOWN)
        $display("test power down done");
        tally_and_finish();
    end
endmodule : prs_sequencer_tb
